// *** logic/sperr_core.sv ***
/*
  serial error responder: receives addressed commands and answers failed
  ones with an error frame carrying a code.
  assumes rxd_i is an asynchronous pin; fault inputs come from logic on
  clock_i; normal answers are produced elsewhere.
*/
`default_nettype none
module sperr_core (
  input wire logic clock_i, // 10 MHz clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic rxd_i, // serial line from master
  output logic txd_o, // serial line to master
  input wire logic adr_lost_i, // pulse: stored address check failed
  input wire logic boot_adr_fail_i, // level at start: address unrecoverable
  input wire logic nvm_fail_i, // pulse: parameter memory fault
  input wire logic pos_fail_i, // level: no valid position now
  output logic cmd_valid_o, // pulse: good command received
  output logic [7:0] cmd_op_o, // command byte of good command
  output logic [7:0] cmd_arg_o, // argument byte of good command
  output logic [7:0] err_code_o, // last code sent
  output logic err_busy_o // error frame being sent
);
  typedef enum logic [3:0] {
    SPERR_IDLE = 4'b0001,
    SPERR_DATA = 4'b0010,
    SPERR_STOP = 4'b0100,
    SPERR_SKIP = 4'b1000
  } sperr_rx_t;

  sperr_rx_t rx_q;
  logic rx_m_q, rx_s_q, rx_p_q;
  logic [13:0] rcnt_q;
  logic [2:0] rbit_q;
  logic [7:0] rsh_q;
  logic byte_v_q, rx_err_q;
  logic [7:0] byte_q;
  logic [2:0] pos_q;
  logic [7:0] op_q, arg_q, chk_q;
  logic pend_q, boot_q;
  logic [7:0] pcode_q;
  logic [2:0] tidx_q;
  logic sending_q;
  logic ev_v;
  logic [7:0] ev_code;
  logic [7:0] sum;
  sperr_tx_if txb ();

  // two-flop synchroniser on the receive pin
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
      rx_p_q <= 1'b1;
    end else begin
      rx_m_q <= rxd_i;
      rx_s_q <= rx_m_q;
      rx_p_q <= rx_s_q;
    end
  end

  // 8N1 receiver sampling mid-bit; a bad stop bit flags a fault
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rx_q <= SPERR_IDLE;
      rcnt_q <= '0;
      rbit_q <= '0;
      rsh_q <= '0;
      byte_v_q <= 1'b0;
      rx_err_q <= 1'b0;
      byte_q <= '0;
    end else begin
      byte_v_q <= 1'b0;
      rx_err_q <= 1'b0;
      case (rx_q)
        SPERR_IDLE: begin
          rcnt_q <= '0;
          if (rx_p_q && !rx_s_q) begin
            rx_q <= SPERR_DATA;
            rbit_q <= '0;
            // counter wraps through zero so the first data sample lands
            // one and a half bits after the start edge, not mid start bit
            rcnt_q <= 14'(0 - sperr_pkg::HALF_CYC);
          end
        end
        SPERR_DATA: begin
          if (rcnt_q == 14'(sperr_pkg::BIT_CYC - 1)) begin
            rcnt_q <= '0;
            rsh_q <= {rx_s_q, rsh_q[7:1]};
            rbit_q <= rbit_q + 3'h1;
            if (rbit_q == 3'h7) begin
              rx_q <= SPERR_STOP;
            end
          end else begin
            rcnt_q <= rcnt_q + 14'h1;
          end
        end
        SPERR_STOP: begin
          if (rcnt_q == 14'(sperr_pkg::BIT_CYC - 1)) begin
            rcnt_q <= '0;
            if (rx_s_q) begin
              byte_v_q <= 1'b1;
              byte_q <= rsh_q;
              rx_q <= SPERR_IDLE;
            end else begin
              rx_err_q <= 1'b1; // wrong baud or break
              rx_q <= SPERR_SKIP;
            end
          end else begin
            rcnt_q <= rcnt_q + 14'h1;
          end
        end
        SPERR_SKIP: begin
          if (rx_s_q) begin
            rx_q <= SPERR_IDLE;
          end
        end
        default: rx_q <= SPERR_IDLE;
      endcase
    end
  end

  // check byte is the 8-bit sum of start, command and argument
  assign sum = 8'(sperr_pkg::BYTE_START + op_q + arg_q);

  // command parser: decides good command or error code
  always_comb begin
    ev_v = 1'b0;
    ev_code = sperr_pkg::ERR_SEQ;
    if (rx_err_q) begin
      ev_v = 1'b1;
      ev_code = sperr_pkg::ERR_RX;
    end else if (byte_v_q && pos_q != 3'h0) begin
      case (pos_q)
        3'h1: begin
          if (byte_q != sperr_pkg::CMD_POS && byte_q != sperr_pkg::CMD_ADR
              && byte_q != sperr_pkg::CMD_ALLOC) begin
            ev_v = 1'b1;
            ev_code = sperr_pkg::ERR_SEQ;
          end
        end
        3'h3: begin
          if (byte_q != sum) begin
            ev_v = 1'b1;
            ev_code = sperr_pkg::ERR_CHK;
          end
        end
        3'h4: begin
          if (byte_q != sperr_pkg::BYTE_END) begin
            ev_v = 1'b1;
            ev_code = sperr_pkg::ERR_SEQ;
          end else if (op_q == sperr_pkg::CMD_ALLOC && (arg_q < sperr_pkg::ADR_LOW
                       || arg_q > sperr_pkg::ADR_HIGH)) begin
            ev_v = 1'b1;
            ev_code = sperr_pkg::ERR_RANGE;
          end else if (op_q == sperr_pkg::CMD_POS && pos_fail_i) begin
            ev_v = 1'b1;
            ev_code = sperr_pkg::ERR_POS;
          end
        end
        default: ev_v = 1'b0;
      endcase
    end
    if (!ev_v && nvm_fail_i) begin
      ev_v = 1'b1;
      ev_code = sperr_pkg::ERR_NVM;
    end else if (!ev_v && (adr_lost_i || boot_q)) begin
      ev_v = 1'b1;
      ev_code = sperr_pkg::ERR_ADRLOST;
    end
  end

  // frame position tracking; any error restarts the hunt for start
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pos_q <= '0;
      op_q <= '0;
      arg_q <= '0;
      chk_q <= '0;
      cmd_valid_o <= 1'b0;
      cmd_op_o <= '0;
      cmd_arg_o <= '0;
    end else begin
      cmd_valid_o <= 1'b0;
      if (ev_v || sending_q) begin
        pos_q <= '0;
      end else if (byte_v_q) begin
        case (pos_q)
          3'h0: if (byte_q == sperr_pkg::BYTE_START) pos_q <= 3'h1;
          3'h1: begin
            op_q <= byte_q;
            pos_q <= 3'h2;
          end
          3'h2: begin
            arg_q <= byte_q;
            pos_q <= 3'h3;
          end
          3'h3: begin
            chk_q <= byte_q;
            pos_q <= 3'h4;
          end
          default: begin
            pos_q <= '0;
            cmd_valid_o <= 1'b1;
            cmd_op_o <= op_q;
            cmd_arg_o <= arg_q;
          end
        endcase
      end
    end
  end

  // pending code latch; boot address fault sampled once after reset
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
      pcode_q <= sperr_pkg::ERR_MIN;
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
      if (ev_v && !pend_q && !sending_q) begin
        pend_q <= boot_q ? boot_adr_fail_i : 1'b1;
        pcode_q <= ev_code; // always within 04h..0Ah
      end else if (pend_q && !sending_q) begin
        pend_q <= 1'b0;
      end
    end
  end

  // error frame sequencer: start, ff, ff, code, end
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sending_q <= 1'b0;
      tidx_q <= '0;
      err_code_o <= sperr_pkg::ERR_MIN;
    end else if (!sending_q) begin
      if (pend_q) begin
        sending_q <= 1'b1;
        tidx_q <= '0;
        err_code_o <= pcode_q;
      end
    end else if (txb.ready) begin
      if (tidx_q == sperr_pkg::FRAME_LEN) begin
        sending_q <= 1'b0; // stop bit of the end byte has left the line
      end else begin
        tidx_q <= tidx_q + 3'h1;
      end
    end
  end

  // no byte offered once all five are handed over; busy waits for the line
  assign txb.valid = sending_q && (tidx_q != sperr_pkg::FRAME_LEN);
  assign err_busy_o = sending_q;

  // byte of the error frame by index
  always_comb begin
    case (tidx_q)
      3'h0: txb.data = sperr_pkg::BYTE_START;
      3'h1: txb.data = sperr_pkg::BYTE_FILL;
      3'h2: txb.data = sperr_pkg::BYTE_FILL;
      3'h3: txb.data = err_code_o;
      default: txb.data = sperr_pkg::BYTE_END;
    endcase
  end

  sperr_uart_tx u_tx (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .tx(txb),
    .txd_o(txd_o)
  );
endmodule : sperr_core
`default_nettype wire

// *** logic/sperr_pkg.sv ***
/*
  shared constants of the serial error responder: frame bytes, error codes,
  uart timing at 10 MHz and 9600 bit/s.
  assumes a single 10 MHz clock and 8N1 characters on the line.
*/
`default_nettype none
package sperr_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned BAUD = 9600;
  localparam int unsigned BIT_CYC = CLK_HZ / BAUD;
  localparam int unsigned HALF_CYC = BIT_CYC / 2;
  localparam logic [7:0] BYTE_START = 8'h02;
  localparam logic [7:0] BYTE_END = 8'h03;
  localparam logic [7:0] BYTE_FILL = 8'hff;
  localparam logic [7:0] CMD_POS = 8'h04;
  localparam logic [7:0] CMD_ADR = 8'h05;
  localparam logic [7:0] CMD_ALLOC = 8'h06;
  localparam logic [7:0] ERR_SEQ = 8'h04;
  localparam logic [7:0] ERR_RX = 8'h05;
  localparam logic [7:0] ERR_RANGE = 8'h06;
  localparam logic [7:0] ERR_ADRLOST = 8'h07;
  localparam logic [7:0] ERR_NVM = 8'h08;
  localparam logic [7:0] ERR_POS = 8'h09;
  localparam logic [7:0] ERR_CHK = 8'h0a;
  localparam logic [7:0] ERR_MIN = 8'h04;
  localparam logic [7:0] ERR_MAX = 8'h0a;
  localparam logic [7:0] ADR_LOW = 8'h0b;
  localparam logic [7:0] ADR_HIGH = 8'h7f;
  localparam logic [2:0] FRAME_LEN = 3'h5;
  localparam logic [2:0] CMD_LEN = 3'h5;
endpackage : sperr_pkg
`default_nettype wire

// *** logic/sperr_tx_if.sv ***
/*
  byte hand-over from the responder core to its uart transmitter.
  assumes both ends share clock_i.
*/
`default_nettype none
interface sperr_tx_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sperr_tx_if
`default_nettype wire

// *** logic/sperr_uart_tx.sv ***
/*
  8N1 uart transmitter for the error responder.
  assumes clock_i at 10 MHz; one byte taken per valid/ready handshake.
*/
`default_nettype none
module sperr_uart_tx (
  input wire logic clock_i, // 10 MHz clock
  input wire logic rst_i, // synchronous reset, high
  sperr_tx_if.snk tx, // byte stream in
  output logic txd_o // serial line out, idle high
);
  logic [13:0] cnt_q;
  logic [3:0] bit_q;
  logic [9:0] sh_q;
  logic busy_q;

  // idle when not shifting
  assign tx.ready = !busy_q;

  // shift start, data lsb first, stop at 9600 bit/s
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
      bit_q <= '0;
      sh_q <= 10'h3ff;
    end else if (!busy_q) begin
      if (tx.valid) begin
        busy_q <= 1'b1;
        sh_q <= {1'b1, tx.data, 1'b0};
        cnt_q <= '0;
        bit_q <= '0;
      end
    end else if (cnt_q == 14'(sperr_pkg::BIT_CYC - 1)) begin
      cnt_q <= '0;
      sh_q <= {1'b1, sh_q[9:1]};
      if (bit_q == 4'h9) begin
        busy_q <= 1'b0;
      end
      bit_q <= bit_q + 4'h1;
    end else begin
      cnt_q <= cnt_q + 14'h1;
    end
  end

  // line is the low bit of the shifter
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      txd_o <= 1'b1;
    end else begin
      txd_o <= busy_q ? sh_q[0] : 1'b1;
    end
  end
endmodule : sperr_uart_tx
`default_nettype wire

// *** test/serial_position_error_responder_test.sv ***
/*
  testbench of the error responder: boot address fault and bad byte sequence.
  assumes sperr_core, sperr_master and the bound checker are compiled first.
*/
`default_nettype none
module serial_position_error_responder_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i, rst_i, boot_adr_fail_i, rxd_i, txd_o, cmd_valid_o, err_busy_o;
  logic [7:0] cmd_op_o, cmd_arg_o, err_code_o;
  int errors = 0;
  int n_checks = 0;
  sperr_core dut (.clock_i(clock_i), .rst_i(rst_i), .rxd_i(rxd_i), .txd_o(txd_o),
    .adr_lost_i(1'b0), .boot_adr_fail_i(boot_adr_fail_i), .nvm_fail_i(1'b0),
    .pos_fail_i(1'b0), .cmd_valid_o(cmd_valid_o), .cmd_op_o(cmd_op_o),
    .cmd_arg_o(cmd_arg_o), .err_code_o(err_code_o), .err_busy_o(err_busy_o));
  sperr_master master (.clock_i(clock_i), .txd_i(txd_o), .rxd_o(rxd_i));
  // 10 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask : check8
  task automatic end_of_test;
    if (errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  // receive and judge one whole error frame
  task automatic get_frame(input logic [7:0] code);
    logic [7:0] b;
    logic [7:0] exp [5];
    exp = '{8'h02, 8'hff, 8'hff, code, 8'h03};
    for (int k = 0; k < 5; k++) begin
      master.get_byte(b);
      check8("frame byte", exp[k], b);
    end
    check8("error code", code, err_code_o);
  endtask : get_frame
  // wait for the frame to end, bounded by two bit times
  task automatic wait_idle;
    for (int k = 0; k < 2 * sperr_pkg::BIT_CYC && err_busy_o === 1'b1; k++) begin
      @(negedge clock_i);
    end
    check8("busy", 8'h00, {7'h00, err_busy_o});
  endtask : wait_idle
  // address unrecoverable at start: frame with code 07h right after reset
  task automatic boot_fault;
    rst_i = 1'b0;
    get_frame(sperr_pkg::ERR_ADRLOST);
    boot_adr_fail_i = 1'b0;
    wait_idle();
  endtask : boot_fault
  // unknown command byte after start: code 04h, then back to idle
  task automatic seq_fault;
    master.send_byte(sperr_pkg::BYTE_START);
    master.send_byte(8'h07);
    get_frame(sperr_pkg::ERR_SEQ);
    wait_idle();
  endtask : seq_fault
  // main sequence
  initial begin
    rst_i = 1'b1;
    boot_adr_fail_i = 1'b1;
    repeat (2) @(negedge clock_i);
    boot_fault();
    seq_fault();
    end_of_test();
  end
  // watchdog against a hang
  initial begin
    repeat (150000) @(posedge clock_i);
    errors++;
    end_of_test();
  end
endmodule : serial_position_error_responder_test
`default_nettype wire

// *** test/sperr_master.sv ***
/*
  bus master model: sends 8N1 characters and receives the device's answers.
  assumes the bench clock of 10 MHz; line is driven after falling edges.
*/
`default_nettype none
module sperr_master (
  input wire logic clock_i, // bench clock
  input wire logic txd_i, // device's serial output
  output logic rxd_o // serial line into the device
);
  timeunit 1ns;
  timeprecision 1ns;
  // line idles high until a character is sent
  initial rxd_o = 1'b1;
  // one bit of idle, start bit, data lsb first; stop bit left standing on return
  task automatic send_byte(input logic [7:0] b);
    rxd_o = 1'b1;
    repeat (sperr_pkg::BIT_CYC) @(negedge clock_i);
    rxd_o = 1'b0;
    repeat (sperr_pkg::BIT_CYC) @(negedge clock_i);
    for (int i = 0; i < 8; i++) begin
      rxd_o = b[i];
      repeat (sperr_pkg::BIT_CYC) @(negedge clock_i);
    end
    rxd_o = 1'b1;
  endtask : send_byte
  // receive one character, sampled mid-bit; caller waits for the answer
  task automatic get_byte(output logic [7:0] b);
    @(negedge txd_i);
    repeat (sperr_pkg::HALF_CYC) @(negedge clock_i);
    for (int i = 0; i < 8; i++) begin
      repeat (sperr_pkg::BIT_CYC) @(negedge clock_i);
      b[i] = txd_i;
    end
  endtask : get_byte
endmodule : sperr_master
`default_nettype wire

// *** test/sperr_monitor.sv ***
/*
  checker of the error responder's ports: frame timing, code range, command pulses.
  assumes it is bound onto sperr_core and that rst_i is synchronous, high.
*/
`default_nettype none
module sperr_monitor (
  input wire logic clock_i, // 10 MHz clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic rxd_i, // serial line in
  input wire logic txd_o, // serial line out
  input wire logic adr_lost_i, // address check failed
  input wire logic boot_adr_fail_i, // address unrecoverable at start
  input wire logic nvm_fail_i, // memory fault
  input wire logic pos_fail_i, // no valid position
  input wire logic cmd_valid_o, // good command pulse
  input wire logic [7:0] cmd_op_o, // command byte
  input wire logic [7:0] cmd_arg_o, // argument byte
  input wire logic [7:0] err_code_o, // code of last frame
  input wire logic err_busy_o // error frame in progress
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic [16:0] run_q;
  // length of the current error frame in cycles
  always_ff @(posedge clock_i) begin
    if (rst_i || !err_busy_o) begin
      run_q <= 17'h0;
    end else begin
      run_q <= run_q + 17'h1;
    end
  end
  // error frame relations
  a_code_in_range: assert property (err_code_o >= 8'h04 && err_code_o <= 8'h0a)
    else $error("error code out of range");
  a_start_bit_next: assert property ($rose(err_busy_o) |=> ##1 !txd_o)
    else $error("no start bit after frame begins");
  a_idle_line_high: assert property (!err_busy_o |-> txd_o)
    else $error("line low outside a frame");
  a_code_held: assert property (err_busy_o && $past(err_busy_o) |-> $stable(err_code_o))
    else $error("code changed within a frame");
  a_frame_length: assert property ($fell(err_busy_o) |-> run_q >= 17'h0c741)
    else $error("error frame too short");
  a_quiet_in_frame: assert property (err_busy_o |-> !cmd_valid_o)
    else $error("command accepted during error frame");
  // good command relations
  a_valid_single: assert property (cmd_valid_o |=> !cmd_valid_o)
    else $error("command pulse longer than one cycle");
  a_op_known: assert property (cmd_valid_o |-> cmd_op_o inside {8'h04, 8'h05, 8'h06})
    else $error("unknown command passed on");
  a_alloc_in_range: assert property (cmd_valid_o && cmd_op_o == 8'h06 |->
    cmd_arg_o >= 8'h0b && cmd_arg_o <= 8'h7f)
    else $error("allocation address out of range passed on");
endmodule : sperr_monitor
bind sperr_core sperr_monitor u_mon (.clock_i(clock_i), .rst_i(rst_i), .rxd_i(rxd_i),
  .txd_o(txd_o), .adr_lost_i(adr_lost_i), .boot_adr_fail_i(boot_adr_fail_i),
  .nvm_fail_i(nvm_fail_i), .pos_fail_i(pos_fail_i), .cmd_valid_o(cmd_valid_o),
  .cmd_op_o(cmd_op_o), .cmd_arg_o(cmd_arg_o), .err_code_o(err_code_o),
  .err_busy_o(err_busy_o));
`default_nettype wire
